// >>> hdl/pges_port_gate.sv
// Port gate, error status, packet counters and receive FIFO
// Contract
// RULE1: Report link good when control characters exchange
// RULE2: Halt control stops all packet issue and accept; code gates accept only, words held in the FIFO or tx register still issue
// RULE3: Data packets pass only with direction enabled
// RULE4: Error flags sticky, cleared by writing one
// RULE5: Error flags never stop packet traffic
// RULE6: Fatal flag discards every packet, maintenance too
// RULE7: Per-port standard and vendor fault cause records
// RULE8: Separate received and sent VC0 packet counters
// RULE9: Counters advance only with count enable set
// RULE10: Port off stops all packets on port; code gates accept only, words held in the FIFO or tx register still issue
// RULE11: Count each whole packet, wrap on overflow
`timescale 1ns/1ps

// ***************************************************************
// Synchronous FIFO with valid and ready on both sides
// ***************************************************************
module pges_fifo #(
  parameter int unsigned WIDTH = 33,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill < (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_fill   = fill;
    if (push && !pop) begin
      next_fill = (AW+1)'(fill + 1'b1);
    end else if (pop && !push) begin
      next_fill = (AW+1)'(fill - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ***************************************************************
// Top: gating of both packet directions and error status
// ***************************************************************
module pges_port_gate (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          link_ctl_ok,
  output logic                               port_link_good,
  input  wire logic                          port_halt_ctl,
  input  wire logic                          port_off_ctl,
  input  wire logic                          input_port_enable,
  input  wire logic                          output_port_enable,
  input  wire logic                          packet_count_enable,
  input  wire logic                          rx_valid,
  output logic                               rx_ready,
  input  wire logic [pges_pkg::DATA_W-1:0]   rx_data,
  input  wire logic                          rx_last,
  input  wire logic                          rx_vc0,
  input  wire logic                          rx_maint,
  output logic                               fab_valid,
  input  wire logic                          fab_ready,
  output logic      [pges_pkg::DATA_W-1:0]   fab_data,
  output logic                               fab_last,
  input  wire logic                          fab_tx_valid,
  output logic                               fab_tx_ready,
  input  wire logic [pges_pkg::DATA_W-1:0]   fab_tx_data,
  input  wire logic                          fab_tx_last,
  input  wire logic                          fab_tx_vc0,
  input  wire logic                          fab_tx_maint,
  output logic                               tx_valid,
  input  wire logic                          tx_ready,
  output logic      [pges_pkg::DATA_W-1:0]   tx_data,
  output logic                               tx_last,
  input  wire logic                          in_err_event,
  input  wire logic                          out_err_event,
  input  wire logic                          fatal_err_event,
  input  wire logic [pges_pkg::CAUSE_W-1:0]  fault_cause_bits,
  input  wire logic [pges_pkg::CAUSE_W-1:0]  vendor_cause_bits,
  input  wire logic                          status_clear_strobe,
  input  wire logic [pges_pkg::STAT_W-1:0]   status_clear_bits,
  input  wire logic                          cause_clear_strobe,
  input  wire logic [pges_pkg::CAUSE_W-1:0]  cause_clear_bits,
  input  wire logic [pges_pkg::CAUSE_W-1:0]  vendor_clear_bits,
  output logic      [pges_pkg::STAT_W-1:0]   port_fault_status,
  output logic      [pges_pkg::CAUSE_W-1:0]  port_fault_cause,
  output logic      [pges_pkg::CAUSE_W-1:0]  port_vendor_fault_cause,
  output logic      [pges_pkg::CNT_W-1:0]    vc0_received_packet_count,
  output logic      [pges_pkg::CNT_W-1:0]    vc0_sent_packet_count
);
  // ***************************************************************
  // Shared gating terms
  // ***************************************************************
  logic port_open;
  logic fatal;

  assign port_open = !port_halt_ctl && !port_off_ctl;  // [RULE2] [RULE10]
  assign fatal     = port_fault_status[pges_pkg::STAT_FATAL];

  // ***************************************************************
  // Receive path
  // ***************************************************************
  pges_pkg::pges_path_t rx_state;
  pges_pkg::pges_path_t next_rx_state;
  logic                 rx_drop_now;
  logic                 rx_take;
  logic                 rx_push;
  logic                 fifo_in_ready;
  logic                 rx_pkt_done;

  always_comb begin
    rx_drop_now = (rx_state == pges_pkg::PGES_DROP);
    if (rx_state == pges_pkg::PGES_IDLE) begin
      rx_drop_now = fatal || (!rx_maint && !input_port_enable);  // [RULE3] [RULE6]
    end
  end

  assign rx_ready    = port_open && (rx_drop_now || fifo_in_ready);  // [RULE2] [RULE10] [RULE5]
  assign rx_take     = rx_valid && rx_ready;
  assign rx_push     = rx_take && !rx_drop_now;
  assign rx_pkt_done = rx_push && rx_last;

  always_comb begin
    next_rx_state = rx_state;
    if (rx_take) begin
      if (rx_last) begin
        next_rx_state = pges_pkg::PGES_IDLE;
      end else begin
        next_rx_state = rx_drop_now ? pges_pkg::PGES_DROP : pges_pkg::PGES_PASS;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state <= pges_pkg::PGES_IDLE;
    end else begin
      rx_state <= next_rx_state;
    end
  end

  pges_fifo #(
    .WIDTH (pges_pkg::DATA_W + 1),
    .DEPTH (pges_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (rx_valid && port_open && !rx_drop_now),
    .in_ready  (fifo_in_ready),
    .in_data   ({rx_last, rx_data}),
    .out_valid (fab_valid),
    .out_ready (fab_ready),
    .out_data  ({fab_last, fab_data})
  );

  // ***************************************************************
  // Transmit path with output register
  // ***************************************************************
  pges_pkg::pges_path_t        tx_state;
  pges_pkg::pges_path_t        next_tx_state;
  logic                        tx_drop_now;
  logic                        tx_take;
  logic                        tx_load;
  logic                        next_tx_valid;
  logic [pges_pkg::DATA_W-1:0] next_tx_data;
  logic                        next_tx_last;
  logic                        tx_pkt_done;

  always_comb begin
    tx_drop_now = (tx_state == pges_pkg::PGES_DROP);
    if (tx_state == pges_pkg::PGES_IDLE) begin
      tx_drop_now = fatal || (!fab_tx_maint && !output_port_enable);  // [RULE3] [RULE6]
    end
  end

  assign fab_tx_ready = port_open && (tx_drop_now || !tx_valid || tx_ready);  // [RULE2] [RULE10]
  assign tx_take      = fab_tx_valid && fab_tx_ready;
  assign tx_load      = tx_take && !tx_drop_now;
  assign tx_pkt_done  = tx_load && fab_tx_last;

  always_comb begin
    next_tx_state = tx_state;
    next_tx_valid = tx_valid && !tx_ready;
    next_tx_data  = tx_data;
    next_tx_last  = tx_last;
    if (tx_take) begin
      if (fab_tx_last) begin
        next_tx_state = pges_pkg::PGES_IDLE;
      end else begin
        next_tx_state = tx_drop_now ? pges_pkg::PGES_DROP : pges_pkg::PGES_PASS;
      end
    end
    if (tx_load) begin
      next_tx_valid = 1'b1;
      next_tx_data  = fab_tx_data;
      next_tx_last  = fab_tx_last;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state <= pges_pkg::PGES_IDLE;
      tx_valid <= 1'b0;
      tx_data  <= pges_pkg::DATA_RESET;
      tx_last  <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      tx_valid <= next_tx_valid;
      tx_data  <= next_tx_data;
      tx_last  <= next_tx_last;
    end
  end

  // ***************************************************************
  // Link good, error flags, fault causes and counters
  // ***************************************************************
  logic                         next_link_good;
  logic [pges_pkg::STAT_W-1:0]  next_status;
  logic [pges_pkg::STAT_W-1:0]  stat_set;
  logic [pges_pkg::STAT_W-1:0]  stat_clr;
  logic [pges_pkg::CAUSE_W-1:0] next_cause;
  logic [pges_pkg::CAUSE_W-1:0] next_vendor;
  logic [pges_pkg::CNT_W-1:0]   next_rx_count;
  logic [pges_pkg::CNT_W-1:0]   next_tx_count;
  logic                         any_err;

  always_comb begin
    next_link_good = link_ctl_ok;  // [RULE1]
    stat_set = '0;
    stat_set[pges_pkg::STAT_IN_ERR]  = in_err_event;
    stat_set[pges_pkg::STAT_OUT_ERR] = out_err_event;
    stat_set[pges_pkg::STAT_FATAL]   = fatal_err_event;
    stat_clr    = status_clear_strobe ? status_clear_bits : '0;
    next_status = (port_fault_status & ~stat_clr) | stat_set;  // [RULE4]
    any_err     = in_err_event || out_err_event || fatal_err_event;
    next_cause  = port_fault_cause;
    next_vendor = port_vendor_fault_cause;
    if (cause_clear_strobe) begin
      next_cause  = next_cause & ~cause_clear_bits;
      next_vendor = next_vendor & ~vendor_clear_bits;
    end
    if (any_err) begin
      next_cause  = next_cause | fault_cause_bits;  // [RULE7]
      next_vendor = next_vendor | vendor_cause_bits;  // [RULE7]
    end
    next_rx_count = vc0_received_packet_count;
    next_tx_count = vc0_sent_packet_count;
    if (packet_count_enable && rx_pkt_done && rx_vc0) begin  // [RULE9] [RULE8]
      next_rx_count = pges_pkg::CNT_W'(vc0_received_packet_count + pges_pkg::CNT_STEP);  // [RULE11]
    end
    if (packet_count_enable && tx_pkt_done && fab_tx_vc0) begin  // [RULE9] [RULE8]
      next_tx_count = pges_pkg::CNT_W'(vc0_sent_packet_count + pges_pkg::CNT_STEP);  // [RULE11]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_link_good            <= 1'b0;
      port_fault_status         <= pges_pkg::STAT_RESET;
      port_fault_cause          <= pges_pkg::CAUSE_RESET;
      port_vendor_fault_cause   <= pges_pkg::CAUSE_RESET;
      vc0_received_packet_count <= pges_pkg::CNT_RESET;
      vc0_sent_packet_count     <= pges_pkg::CNT_RESET;
    end else begin
      port_link_good            <= next_link_good;
      port_fault_status         <= next_status;
      port_fault_cause          <= next_cause;
      port_vendor_fault_cause   <= next_vendor;
      vc0_received_packet_count <= next_rx_count;
      vc0_sent_packet_count     <= next_tx_count;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_link_good_follow: assert property (  // [RULE1]
    ##1 (port_link_good == $past(link_ctl_ok)))
    else $error("link good does not follow control exchange");
  a_halt_stops_port: assert property (  // [RULE2]
    port_halt_ctl |-> (!rx_ready && !fab_tx_ready))
    else $error("halted port accepted a packet word");
  a_off_stops_port: assert property (  // [RULE10]
    port_off_ctl |-> ##1 (!$past(rx_push) && !$past(tx_load)))
    else $error("port off still passed a word");
  a_rx_enable_gate: assert property (  // [RULE3]
    (rx_state == pges_pkg::PGES_IDLE && rx_take && !rx_maint && !input_port_enable)
      |-> !rx_push)
    else $error("data packet received while input disabled");
  a_tx_enable_gate: assert property (  // [RULE3]
    (tx_state == pges_pkg::PGES_IDLE && !fab_tx_maint && !output_port_enable && !tx_ready)
      |=> $stable(tx_valid) or $fell(tx_valid))
    else $error("data packet sent while output disabled");
  a_flag_sticky_set: assert property (  // [RULE4]
    in_err_event |=> port_fault_status[pges_pkg::STAT_IN_ERR])
    else $error("input error flag not set or lost to clear");
  a_flag_w1c_clear: assert property (  // [RULE4]
    (status_clear_strobe && status_clear_bits[pges_pkg::STAT_OUT_ERR] && !out_err_event)
      |=> !port_fault_status[pges_pkg::STAT_OUT_ERR])
    else $error("output error flag not cleared by write one");
  a_flag_no_stop: assert property (  // [RULE5]
    (port_open && !fatal && rx_state == pges_pkg::PGES_PASS && fifo_in_ready) |-> rx_ready)
    else $error("error flag stalled receive traffic");
  a_fatal_drops_all: assert property (  // [RULE6]
    (fatal && rx_state == pges_pkg::PGES_IDLE && port_open) |-> (rx_ready && !rx_push))
    else $error("packet passed while fatal flag set");
  a_cause_capture: assert property (  // [RULE7]
    (fatal_err_event && fault_cause_bits != '0)
      |=> ((port_fault_cause & $past(fault_cause_bits)) == $past(fault_cause_bits)))
    else $error("fault cause not recorded");
  a_count_gate: assert property (  // [RULE9]
    !packet_count_enable |=> $stable(vc0_received_packet_count) && $stable(vc0_sent_packet_count))
    else $error("counter moved while disabled");
  a_count_step: assert property (  // [RULE11] [RULE8]
    (packet_count_enable && rx_pkt_done && rx_vc0)
      |=> (vc0_received_packet_count == pges_pkg::CNT_W'($past(vc0_received_packet_count) + 1'b1)))
    else $error("received counter did not step by one");

  c_rx_packet: cover property (rx_pkt_done ##1 fab_valid);
  c_tx_packet: cover property (tx_pkt_done ##1 (tx_valid && tx_ready));
  c_fatal_drop: cover property (fatal && rx_take);
  c_set_over_clear: cover property (in_err_event && status_clear_strobe && status_clear_bits[0]);
endmodule

// >>> common/pges_pkg.sv
// Constants and types shared by the port gate and error status block
package pges_pkg;

  // ***************************************************************
  // Widths and depths
  // ***************************************************************
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned CNT_W      = 32;
  localparam int unsigned CAUSE_W    = 32;
  localparam int unsigned STAT_W     = 3;

  // ***************************************************************
  // Status flag positions (write one to clear)
  // ***************************************************************
  localparam int unsigned STAT_IN_ERR  = 0;
  localparam int unsigned STAT_OUT_ERR = 1;
  localparam int unsigned STAT_FATAL   = 2;

  // ***************************************************************
  // Values after reset and counter step
  // ***************************************************************
  localparam logic [STAT_W-1:0]  STAT_RESET  = 3'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0]   CNT_RESET   = 32'h0000_0000;
  localparam logic [CNT_W-1:0]   CNT_STEP    = 32'h0000_0001;
  localparam logic [DATA_W-1:0]  DATA_RESET  = 32'h0000_0000;

  // ***************************************************************
  // Packet path state
  // ***************************************************************
  typedef enum logic [1:0] {
    PGES_IDLE,
    PGES_PASS,
    PGES_DROP
  } pges_path_t;

endpackage

// >>> testbench/pges_link_model.sv
// Link endpoint model: packet source into the port and sink of its output
`timescale 1ns/1ps
module pges_link_model (
  input  wire logic        clk,
  input  wire logic        slow,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [31:0]      rx_data,
  output logic             rx_last,
  output logic             rx_vc0,
  output logic             rx_maint,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_last
);
  // ***************************************************************
  // Source and sink
  // ***************************************************************
  int          taken = 0;
  int          stuck = 0;
  logic        rdy   = 1'h0;
  logic [32:0] tx_q[$];
  assign tx_ready = rdy;
  initial {rx_valid, rx_data, rx_last, rx_vc0, rx_maint} = '0;
  // Takes output words at full rate, or every other cycle when slow
  always @(posedge clk) begin
    if (tx_valid && tx_ready) tx_q.push_back({tx_last, tx_data});
    rdy <= slow ? !rdy : 1'h1;
  end
  task automatic send(input int n, input logic vc0, input logic maint, input logic [31:0] base);
    int w;
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'h1;
      rx_data  = base + 32'(i);
      rx_last  = (i == n - 1);
      rx_vc0   = vc0;
      rx_maint = maint;
      w = 0;
      @(negedge clk);
      while (rx_ready !== 1'h1 && w < 200) begin
        @(negedge clk);
        w++;
      end
      if (w == 200) stuck++;
      @(posedge clk);
      #1;
      taken++;
    end
    rx_valid = 1'h0;
    // Released data lines must not keep showing the last word
    rx_data  = ~rx_data;
    // Idle stands for one edge before the next packet may start
    @(posedge clk);
    #1;
  endtask
endmodule

// >>> testbench/pges_port_gate_test.sv
// Self-checking bench for the port gate and error status block
`timescale 1ns/1ps
module pges_port_gate_test;
  // ***************************************************************
  // Stimulus, sinks and design
  // ***************************************************************
  logic        clk, sys_rst, link_ctl_ok, port_halt_ctl, port_off_ctl, slow, fab_ready;
  logic        input_port_enable, output_port_enable, packet_count_enable, in_err_event;
  logic        fab_tx_valid, fab_tx_last, fab_tx_vc0, fab_tx_maint, out_err_event;
  logic        fatal_err_event, status_clear_strobe, cause_clear_strobe, port_link_good;
  logic        rx_valid, rx_ready, rx_last, rx_vc0, rx_maint, fab_valid, fab_last;
  logic        fab_tx_ready, tx_valid, tx_ready, tx_last;
  logic [2:0]  status_clear_bits, port_fault_status;
  logic [31:0] fab_tx_data, fault_cause_bits, vendor_cause_bits, cause_clear_bits;
  logic [31:0] vendor_clear_bits, rx_data, fab_data, tx_data, port_fault_cause;
  logic [31:0] port_vendor_fault_cause, vc0_received_packet_count, vc0_sent_packet_count;
  logic [32:0] fab_q[$];
  int          errors          = 0;
  int          samples_checked = 0;
  logic [31:0] exp_rx          = 32'h0;
  logic [31:0] exp_tx          = 32'h0;

  pges_port_gate dut (.clk, .sys_rst, .link_ctl_ok, .port_link_good, .port_halt_ctl,
    .port_off_ctl, .input_port_enable, .output_port_enable, .packet_count_enable, .rx_valid,
    .rx_ready, .rx_data, .rx_last, .rx_vc0, .rx_maint, .fab_valid, .fab_ready, .fab_data,
    .fab_last, .fab_tx_valid, .fab_tx_ready, .fab_tx_data, .fab_tx_last, .fab_tx_vc0,
    .fab_tx_maint, .tx_valid, .tx_ready, .tx_data, .tx_last, .in_err_event, .out_err_event,
    .fatal_err_event, .fault_cause_bits, .vendor_cause_bits, .status_clear_strobe,
    .status_clear_bits, .cause_clear_strobe, .cause_clear_bits, .vendor_clear_bits,
    .port_fault_status, .port_fault_cause, .port_vendor_fault_cause,
    .vc0_received_packet_count, .vc0_sent_packet_count);
  pges_link_model link (.clk, .slow, .rx_valid, .rx_ready, .rx_data, .rx_last, .rx_vc0,
    .rx_maint, .tx_valid, .tx_ready, .tx_data, .tx_last);

  initial clk = 1'h0;
  always #4 clk = ~clk;
  always @(posedge clk) if (fab_valid && fab_ready) fab_q.push_back({fab_last, fab_data});

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic results();
    errors += link.stuck;
    $display("Checked %0d values, %0d mismatches", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rx_pkt(input int n, input logic v, input logic m, input logic [31:0] b);
    link.send(n, v, m, b);
    if (link.stuck > 0) results();
  endtask
  task automatic tx_pkt(input int n, input logic v, input logic m, input logic [31:0] b);
    int w;
    for (int i = 0; i < n; i++) begin
      {fab_tx_valid, fab_tx_data, fab_tx_last} = {1'h1, b + 32'(i), i == n - 1};
      {fab_tx_vc0, fab_tx_maint} = {v, m};
      w = 0;
      @(negedge clk);
      while (fab_tx_ready !== 1'h1 && w < 200) begin
        @(negedge clk);
        w++;
      end
      if (w == 200) begin
        errors++;
        results();
      end
      tick(1);
    end
    fab_tx_valid = 1'h0;
    fab_tx_data  = ~fab_tx_data;
    tick(1);
  endtask
  task automatic expect_pkt(ref logic [32:0] q[$], input int n, input logic [31:0] b);
    logic [32:0] e;
    int          w = 0;
    while (q.size() < n && w < 300) begin
      tick(1);
      w++;
    end
    chk(32'(q.size()), 32'(n));
    if (q.size() < n) results();
    for (int i = 0; i < n && q.size() > 0; i++) begin
      e = q.pop_front();
      chk(e, {i == n - 1, b + 32'(i)});
    end
  endtask
  task automatic counts(input string s);
    tick(2);
    chk(vc0_received_packet_count, exp_rx);
    chk(vc0_sent_packet_count, exp_tx);
    $display("Test %s done", s);
  endtask
  task automatic pulse(input logic [2:0] ev, input logic [2:0] clr, input logic [31:0] c,
                       input logic [31:0] v, input logic [31:0] cc, input logic [31:0] vc);
    {fatal_err_event, out_err_event, in_err_event} = ev;
    {status_clear_strobe, status_clear_bits} = {|clr, clr};
    {fault_cause_bits, vendor_cause_bits} = {c, v};
    {cause_clear_strobe, cause_clear_bits, vendor_clear_bits} = {|{cc, vc}, cc, vc};
    tick(1);
    {fatal_err_event, out_err_event, in_err_event, status_clear_strobe} = '0;
    cause_clear_strobe = 1'h0;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_link();
    chk(port_link_good, 1'h0);
    link_ctl_ok = 1'h1;
    tick(1);
    chk(port_link_good, 1'h1);
    link_ctl_ok = 1'h0;
    tick(1);
    chk(port_link_good, 1'h0);
    $display("Test link done");
  endtask
  task automatic t_rx();
    int t0;
    rx_pkt(1, 1'h1, 1'h0, 32'h100);
    expect_pkt(fab_q, 1, 32'h100);
    rx_pkt(3, 1'h1, 1'h0, 32'h200);
    expect_pkt(fab_q, 3, 32'h200);
    rx_pkt(2, 1'h0, 1'h0, 32'h300);
    expect_pkt(fab_q, 2, 32'h300);
    exp_rx += 32'h2;
    fab_ready = 1'h0;
    t0 = link.taken;
    fork
      rx_pkt(33, 1'h1, 1'h0, 32'h1000);
    join_none
    tick(45);
    chk(32'(link.taken - t0), 32'h20);
    chk(rx_ready, 1'h0);
    fab_ready = 1'h1;
    expect_pkt(fab_q, 33, 32'h1000);
    exp_rx += 32'h1;
    counts("receive");
  endtask
  task automatic t_gate();
    for (int k = 0; k < 2; k++) begin
      {port_halt_ctl, port_off_ctl} = {k == 0, k == 1};
      fork
        rx_pkt(1, 1'h1, 1'h1, 32'h500);
        tx_pkt(1, 1'h1, 1'h0, 32'h600);
      join_none
      tick(12);
      chk({rx_ready, fab_tx_ready, tx_valid}, 32'h0);
      chk(32'(fab_q.size() + link.tx_q.size()), 32'h0);
      {port_halt_ctl, port_off_ctl} = 2'h0;
      expect_pkt(fab_q, 1, 32'h500);
      expect_pkt(link.tx_q, 1, 32'h600);
      exp_rx += 32'h1;
      exp_tx += 32'h1;
    end
    counts("gate");
  endtask
  task automatic t_tx();
    slow = 1'h1;
    tx_pkt(4, 1'h1, 1'h0, 32'h700);
    expect_pkt(link.tx_q, 4, 32'h700);
    output_port_enable = 1'h0;
    tx_pkt(2, 1'h1, 1'h0, 32'h800);
    tx_pkt(1, 1'h1, 1'h1, 32'h900);
    expect_pkt(link.tx_q, 1, 32'h900);
    exp_tx += 32'h2;
    input_port_enable = 1'h0;
    rx_pkt(2, 1'h1, 1'h0, 32'hA00);
    rx_pkt(1, 1'h1, 1'h1, 32'hB00);
    expect_pkt(fab_q, 1, 32'hB00);
    {input_port_enable, output_port_enable, packet_count_enable} = 3'h6;
    exp_rx += 32'h1;
    rx_pkt(1, 1'h1, 1'h0, 32'hC00);
    tx_pkt(1, 1'h1, 1'h0, 32'hD00);
    expect_pkt(fab_q, 1, 32'hC00);
    expect_pkt(link.tx_q, 1, 32'hD00);
    counts("transmit");
    {packet_count_enable, slow} = 2'h2;
  endtask
  task automatic t_status();
    pulse(3'h1, 3'h0, 32'h11, 32'h22, 32'h0, 32'h0);
    chk(port_fault_status, 3'h1);
    pulse(3'h2, 3'h0, 32'h4, 32'h0, 32'h0, 32'h0);
    chk({port_fault_cause, port_vendor_fault_cause}, {32'h15, 32'h22});
    rx_pkt(1, 1'h1, 1'h0, 32'hE00);
    tx_pkt(1, 1'h1, 1'h0, 32'hE80);
    expect_pkt(fab_q, 1, 32'hE00);
    expect_pkt(link.tx_q, 1, 32'hE80);
    {exp_rx, exp_tx} = {exp_rx + 32'h1, exp_tx + 32'h1};
    pulse(3'h1, 3'h3, 32'h0, 32'h0, 32'h1, 32'h22);
    chk(port_fault_status, 3'h1);
    chk({port_fault_cause, port_vendor_fault_cause}, {32'h14, 32'h0});
    pulse(3'h0, 3'h1, 32'h0, 32'h0, 32'h0, 32'h0);
    chk(port_fault_status, 3'h0);
    pulse(3'h4, 3'h0, 32'h0, 32'h0, 32'h0, 32'h0);
    chk(port_fault_status, 3'h4);
    rx_pkt(1, 1'h1, 1'h1, 32'hF00);
    rx_pkt(2, 1'h1, 1'h0, 32'hF10);
    tx_pkt(1, 1'h1, 1'h1, 32'hF20);
    tick(10);
    chk(32'(fab_q.size() + link.tx_q.size()), 32'h0);
    pulse(3'h0, 3'h4, 32'h0, 32'h0, 32'h0, 32'h0);
    chk(port_fault_status, 3'h0);
    rx_pkt(1, 1'h1, 1'h1, 32'h1100);
    expect_pkt(fab_q, 1, 32'h1100);
    exp_rx += 32'h1;
    counts("status");
  endtask

  initial begin
    {sys_rst, link_ctl_ok, port_halt_ctl, port_off_ctl, slow, fab_ready} = 6'h21;
    {input_port_enable, output_port_enable, packet_count_enable} = 3'h7;
    {fab_tx_valid, fab_tx_last, fab_tx_vc0, fab_tx_maint, fab_tx_data} = '0;
    {in_err_event, out_err_event, fatal_err_event, status_clear_strobe} = '0;
    {status_clear_bits, cause_clear_strobe, cause_clear_bits, vendor_clear_bits} = '0;
    {fault_cause_bits, vendor_cause_bits} = '0;
    tick(16);
    sys_rst = 1'h0;
    t_link();
    t_rx();
    t_gate();
    t_tx();
    t_status();
    results();
  end
  initial begin
    #400000;
    errors++;
    results();
  end
endmodule
